// ===== verilog/pdm_pkg.sv
/*
 Package for the power-down mode controller: register offsets, field
 positions, reset values, mode and state encodings, timing constants.
 Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package pdm_pkg;

   // Register byte offsets
   localparam logic [3:0] PDM_OFS_HW_POWERDOWN_PIN_N_CTRL = 4'h0;
   localparam logic [3:0] PDM_OFS_CONTROL = 4'h4;
   localparam logic [3:0] PDM_OFS_STATUS = 4'h8;

   // Standby control register layout
   localparam int PDM_SSB_POS = 7;
   localparam logic [7:0] PDM_HW_POWERDOWN_PIN_N_CTRL_RESET = 8'h7f;
   localparam logic [6:0] PDM_HW_POWERDOWN_PIN_N_CTRL_RSVD = 7'h7f;

   // Control register field positions
   localparam int PDM_WDT_RUN_POS = 0;
   localparam int PDM_MASK_POS = 4;
   localparam logic [2:0] PDM_MASK_RESET = 3'h0;
   localparam logic PDM_WDT_RUN_RESET = 1'b0;

   // Settle time after oscillator restart on NMI exit, in ns
   localparam int PDM_OSC_SETTLE_NS = 200;
   localparam int PDM_CLK_PERIOD_NS = 10;
   localparam int PDM_OSC_SETTLE_CYC = (PDM_OSC_SETTLE_NS + PDM_CLK_PERIOD_NS - 1) / PDM_CLK_PERIOD_NS;

   typedef enum logic [2:0]
   {
      PDM_ST_RESET = 3'b000,
      PDM_ST_RUN = 3'b001,
      PDM_ST_SLEEP = 3'b010,
      PDM_ST_SW_HW_POWERDOWN_PIN_N = 3'b011,
      PDM_ST_NMI_WAKE = 3'b100,
      PDM_ST_HW_HW_POWERDOWN_PIN_N = 3'b101,
      PDM_ST_XFER = 3'b110
   } pdm_state_type;

   // Outgoing power control bundle
   typedef struct packed
   {
      logic clock_run;
      logic cpu_run;
      logic modules_run;
      logic modules_init;
      logic cpu_regs_init;
      logic ports_hiz;
   } pdm_power_type;

   // Wake request bundle from the interrupt logic
   typedef struct packed
   {
      logic irq_valid;
      logic [2:0] irq_level;
      logic irq_to_xfer;
      logic nmi;
   } pdm_wake_type;

endpackage

// ===== verilog/pdm_controller.sv
/*
 Power-down mode controller. Places the chip in sleep, software standby or
 hardware standby and brings it back out; drives clock, CPU and module gates.
 Assumes sleep_exec, wake and transfer signals come from logic on ref_clk;
 the two pins arrive asynchronously and are synchronised here.
*/
// The Avalon-MM register port and the placing of the registers were decided locally.
// Overview of operation
// - Sleep with select bit clear halts CPU; clock, modules, RAM, ports keep running.
// - Software standby entered only from run by sleep instruction; sleep from run by it, or after a transfer.
// - Software standby stops clock, CPU, modules; partly resets modules; keeps CPU state.
// - Software standby needs watchdog stopped and select bit set at sleep.
// - Low hardware-standby pin forces hardware standby from any state.
// - Hardware standby halts all, resets CPU registers and modules, ports high-impedance.
// - Software standby left only by NMI, reset pin low, or standby pin low.
// - Sleep ends on any interrupt, reset pin low, or standby pin low.
// - Waking interrupt starts CPU interrupt handling or a controller transfer.
// - After a waking transfer, CPU resumes unless transfer count reached zero.
// - Interrupts at or below status mask level stay pending, do not wake.
// - Disabled module interrupts make no request and cannot wake.
// - Reset pin low during sleep goes straight to reset state.
// - Bit 7 of standby control selects standby over sleep; resets to zero.
// - Setting the select bit is ignored while watchdog run bit is one.
// - Select bit clears on NMI recovery, reset, or hardware standby entry.
// - Hardware standby exit: pin high, reset held low, reset sequence on release.
`timescale 1ns/1ps

module pdm_controller
   import pdm_pkg::*;
#(
   parameter int SETTLE_CYC = PDM_OSC_SETTLE_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // External pins
   input wire logic chip_init_pin_n,
   input wire logic hw_powerdown_pin_n,
   // CPU and interrupt logic
   input wire logic sleep_exec,
   input wire pdm_wake_type wake,
   input wire logic module_irq_enable,
   input wire logic xfer_done,
   input wire logic xfer_count_zero,
   // Power control outputs
   output pdm_power_type power,
   output pdm_state_type mode,
   output logic cpu_resume,
   output logic irq_take,
   output logic xfer_start,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // Settle counter is 16 bits wide and must count at least one cycle
   if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
   begin : settle_range_chk
      $error("SETTLE_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree

   logic [2:0] hw_powerdown_pin_n_sync_reg;
   logic [2:0] init_sync_reg;
   logic hw_powerdown_pin_n_n_reg;
   logic init_n_reg;

   // Stage 1 may go metastable; only stages 2 and 3 are compared
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         hw_powerdown_pin_n_sync_reg <= 3'h7;
      else
         hw_powerdown_pin_n_sync_reg <= {hw_powerdown_pin_n_sync_reg[1:0], hw_powerdown_pin_n};
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         init_sync_reg <= 3'h0;
      else
         init_sync_reg <= {init_sync_reg[1:0], chip_init_pin_n};
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         hw_powerdown_pin_n_n_reg <= 1'b1;
      else if (hw_powerdown_pin_n_sync_reg[1] == hw_powerdown_pin_n_sync_reg[2])
         hw_powerdown_pin_n_n_reg <= hw_powerdown_pin_n_sync_reg[2];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         init_n_reg <= 1'b0;
      else if (init_sync_reg[1] == init_sync_reg[2])
         init_n_reg <= init_sync_reg[2];
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake qualification

   logic irq_wakes;
   logic bus_wr_hit;
   logic ssb_reg;
   logic wdt_run_reg;
   logic [2:0] mask_reg;
   pdm_state_type state_reg;
   pdm_state_type state_next;
   logic [15:0] settle_reg;

   // Masked or disabled requests stay pending and do not end sleep
   assign irq_wakes = wake.irq_valid && module_irq_enable && (wake.irq_level > mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // Mode state machine

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PDM_ST_RESET:
            if (init_n_reg)
               state_next = PDM_ST_RUN;
         PDM_ST_RUN:
            if (sleep_exec)
            begin
               if (ssb_reg && !wdt_run_reg)
                  state_next = PDM_ST_SW_HW_POWERDOWN_PIN_N;
               else
                  state_next = PDM_ST_SLEEP;
            end
         PDM_ST_SLEEP:
            if (irq_wakes || wake.nmi)
               state_next = (wake.irq_to_xfer && !wake.nmi) ? PDM_ST_XFER : PDM_ST_RUN;
         PDM_ST_XFER:
            if (xfer_done)
               state_next = xfer_count_zero ? PDM_ST_SLEEP : PDM_ST_RUN;
         PDM_ST_SW_HW_POWERDOWN_PIN_N:
            if (wake.nmi)
               state_next = PDM_ST_NMI_WAKE;
         PDM_ST_NMI_WAKE:
            if (settle_reg == 16'h0000)
               state_next = PDM_ST_RUN;
         PDM_ST_HW_HW_POWERDOWN_PIN_N:
            state_next = PDM_ST_HW_HW_POWERDOWN_PIN_N;
         default:
            state_next = PDM_ST_RESET;
      endcase
      // Reset pin overrides everything except hardware standby
      if (!init_n_reg && state_reg != PDM_ST_HW_HW_POWERDOWN_PIN_N)
         state_next = PDM_ST_RESET;
      // Standby pin low wins; on rise, go to reset and stay there until the init pin is high
      if (!hw_powerdown_pin_n_n_reg)
         state_next = PDM_ST_HW_HW_POWERDOWN_PIN_N;
      else if (state_reg == PDM_ST_HW_HW_POWERDOWN_PIN_N)
         state_next = PDM_ST_RESET;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= PDM_ST_RESET;
      else
         state_reg <= state_next;
   end

   // Oscillator settle count after NMI leaves software standby
   // Reloaded every standby cycle, so each NMI exit waits the full time
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         settle_reg <= 16'h0000;
      else if (state_reg == PDM_ST_SW_HW_POWERDOWN_PIN_N)
         settle_reg <= 16'(SETTLE_CYC - 1);
      else if (settle_reg != 16'h0000)
         settle_reg <= settle_reg - 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode functions

   // One place decides what each mode gates, so entry and exit stay consistent
   function automatic pdm_power_type power_for(input pdm_state_type st);
      pdm_power_type p;
      p = '0;
      case (st)
         PDM_ST_RUN:
         begin
            p.clock_run = 1'b1;
            p.cpu_run = 1'b1;
            p.modules_run = 1'b1;
         end
         PDM_ST_SLEEP, PDM_ST_XFER:
         begin
            p.clock_run = 1'b1;
            p.modules_run = 1'b1;
         end
         PDM_ST_NMI_WAKE:
            p.clock_run = 1'b1;
         PDM_ST_SW_HW_POWERDOWN_PIN_N:
            p.modules_init = 1'b1;
         PDM_ST_HW_HW_POWERDOWN_PIN_N:
         begin
            p.modules_init = 1'b1;
            p.cpu_regs_init = 1'b1;
            p.ports_hiz = 1'b1;
         end
         default:
         begin
            p.clock_run = 1'b1;
            p.modules_init = 1'b1;
            p.cpu_regs_init = 1'b1;
         end
      endcase
      return p;
   endfunction

   // Register decode shared by the write and read paths
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
      return addr == ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Output gating

   // Gates follow the next state, so they change on the same edge as mode
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         power <= '0;
      else
         power <= power_for(state_next);
   end

   // Registered pulses, decoded from the transition about to be taken
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         cpu_resume <= 1'b0;
      else
         cpu_resume <= (state_reg == PDM_ST_XFER) && (state_next == PDM_ST_RUN);
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_take <= 1'b0;
      else
         irq_take <= (state_next == PDM_ST_RUN) && ((state_reg == PDM_ST_SLEEP)
            || (state_reg == PDM_ST_NMI_WAKE));
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         xfer_start <= 1'b0;
      else
         xfer_start <= (state_reg == PDM_ST_SLEEP) && (state_next == PDM_ST_XFER);
   end

   assign mode = state_reg;

   ////////////////////////////////////////////////////////////////////////
   // Registers

   assign bus_wr_hit = avs_write && !avs_waitrequest;

   // Clear beats a same-edge write, so no set survives reset or hardware standby entry
   logic ssb_clear;

   assign ssb_clear = (state_next == PDM_ST_HW_HW_POWERDOWN_PIN_N) || (state_next == PDM_ST_RESET)
      || ((state_reg == PDM_ST_NMI_WAKE) && (state_next == PDM_ST_RUN));

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ssb_reg <= PDM_HW_POWERDOWN_PIN_N_CTRL_RESET[PDM_SSB_POS];
      else if (ssb_clear)
         ssb_reg <= 1'b0;
      else if (bus_wr_hit && reg_hit(avs_address, PDM_OFS_HW_POWERDOWN_PIN_N_CTRL) && avs_byteenable[0])
      begin
         if (!(avs_writedata[PDM_SSB_POS] && wdt_run_reg))
            ssb_reg <= avs_writedata[PDM_SSB_POS];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         wdt_run_reg <= PDM_WDT_RUN_RESET;
      else if (bus_wr_hit && reg_hit(avs_address, PDM_OFS_CONTROL) && avs_byteenable[0])
         wdt_run_reg <= avs_writedata[PDM_WDT_RUN_POS];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         mask_reg <= PDM_MASK_RESET;
      else if (bus_wr_hit && reg_hit(avs_address, PDM_OFS_CONTROL) && avs_byteenable[0])
         mask_reg <= avs_writedata[PDM_MASK_POS +: 3];
   end

   // One wait state per access keeps read data registered
   // Trade-off: every access costs a cycle, but the read mux sits behind a flop
   logic ack_reg;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= (avs_read || avs_write) && !ack_reg;
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read)
      begin
         if (reg_hit(avs_address, PDM_OFS_HW_POWERDOWN_PIN_N_CTRL))
            avs_readdata <= {24'h000000, ssb_reg, PDM_HW_POWERDOWN_PIN_N_CTRL_RSVD};
         else if (reg_hit(avs_address, PDM_OFS_CONTROL))
            avs_readdata <= {25'h0, mask_reg, 3'h0, wdt_run_reg};
         else if (reg_hit(avs_address, PDM_OFS_STATUS))
            avs_readdata <= {29'h0, state_reg};
         else
            avs_readdata <= 32'h0000_0000;
      end
   end

endmodule

// ===== tb/pdm_chk.sv
/*
 Checker for the power-down controller: mode, power gates and wake paths.
 Sees only controller ports; bound to every controller instance below.
*/
`timescale 1ns/1ps
module pdm_chk
   import pdm_pkg::*;
(
   // Clock, reset, pins
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chip_init_pin_n,
   input wire logic hw_powerdown_pin_n,
   // Wake side
   input wire logic sleep_exec,
   input wire pdm_wake_type wake,
   input wire logic module_irq_enable,
   input wire logic xfer_done,
   input wire logic xfer_count_zero,
   // Outputs
   input wire pdm_power_type power,
   input wire pdm_state_type mode,
   input wire logic cpu_resume,
   input wire logic irq_take
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!reset_n);
// Pins pass a 3-stage sync, so pin checks wait 6 edges
wire pins_hi = chip_init_pin_n && hw_powerdown_pin_n;
///////////////////////////////////////////////////////////////////////////
sleep_power_a:
assert property (mode == PDM_ST_SLEEP |-> power.clock_run && power.modules_run && !power.cpu_run)
   else $error("sleep gates wrong");
sw_power_a:
assert property (mode == PDM_ST_SW_HW_POWERDOWN_PIN_N |-> !power.clock_run && !power.cpu_run && !power.modules_run)
   else $error("standby gates wrong");
hw_power_a:
assert property (mode == PDM_ST_HW_HW_POWERDOWN_PIN_N |-> power.ports_hiz && !power.cpu_run && !power.clock_run)
   else $error("hw standby gates wrong");
sleep_entry_a:
assert property ($changed(mode) && mode == PDM_ST_SLEEP |-> $past(mode) inside {PDM_ST_RUN, PDM_ST_XFER})
   else $error("sleep entered from wrong state");
sw_entry_a:
assert property ($changed(mode) && mode == PDM_ST_SW_HW_POWERDOWN_PIN_N |-> $past(mode) == PDM_ST_RUN && $past(sleep_exec))
   else $error("standby entered wrongly");
sw_exit_a:
assert property ($past(mode) == PDM_ST_SW_HW_POWERDOWN_PIN_N && mode != PDM_ST_SW_HW_POWERDOWN_PIN_N
   |-> mode inside {PDM_ST_NMI_WAKE, PDM_ST_RESET, PDM_ST_HW_HW_POWERDOWN_PIN_N}) else $error("bad standby exit");
hw_force_a:
assert property ((!hw_powerdown_pin_n) [*6] |-> mode == PDM_ST_HW_HW_POWERDOWN_PIN_N) else $error("hw standby missed");
init_force_a:
assert property ((!chip_init_pin_n && hw_powerdown_pin_n) [*6] |-> mode == PDM_ST_RESET)
   else $error("reset state missed");
blocked_irq_a:
assert property ((mode == PDM_ST_SLEEP && !module_irq_enable && !wake.nmi && pins_hi) [*4] |=> mode == PDM_ST_SLEEP)
   else $error("disabled irq woke");
wake_take_a:
assert property ($past(mode) == PDM_ST_SLEEP && mode == PDM_ST_RUN |-> irq_take) else $error("no irq take");
xfer_resume_a:
assert property (mode == PDM_ST_XFER && xfer_done && !xfer_count_zero && pins_hi
   |=> mode == PDM_ST_RUN && cpu_resume) else $error("no resume after transfer");
cover property (mode == PDM_ST_SW_HW_POWERDOWN_PIN_N ##1 mode == PDM_ST_NMI_WAKE);
cover property (mode == PDM_ST_XFER ##1 mode == PDM_ST_RUN);
cover property (mode == PDM_ST_HW_HW_POWERDOWN_PIN_N);
endmodule
bind pdm_controller pdm_chk chk_u (.ref_clk, .reset_n, .chip_init_pin_n, .hw_powerdown_pin_n, .sleep_exec,
   .wake, .module_irq_enable, .xfer_done, .xfer_count_zero, .power, .mode, .cpu_resume, .irq_take);

// ===== tb/pdm_xfer_model.sv
/*
 Transfer controller model: serves a waking transfer and reports its end.
 Assumes xfer_start is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ps
module pdm_xfer_model
#(
   parameter int XFER_CYC = 4
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Transfer handshake
   input wire logic xfer_start,
   input wire logic end_at_zero,
   output logic xfer_done,
   output logic xfer_count_zero
);
int cnt_reg;
always_ff @(posedge ref_clk or negedge reset_n)
   if (!reset_n)
   begin
      cnt_reg <= 0;
      xfer_done <= 1'b0;
      xfer_count_zero <= 1'b0;
   end
   else
   begin
      cnt_reg <= xfer_start ? XFER_CYC : (cnt_reg > 0 ? cnt_reg - 1 : 0);
      xfer_done <= (cnt_reg == 1);
      // Count flag only means something with done; flip it otherwise
      xfer_count_zero <= (cnt_reg == 1) ? end_at_zero : !end_at_zero;
   end
endmodule

// ===== tb/tb_top.sv
/*
 Testbench for the power-down controller: bus tasks and mode sequences.
 Assumes the checker is bound and the transfer model stands beside.
*/
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb_top
   import pdm_pkg::*;
;
logic ref_clk = 0, reset_n = 0, init_n = 1, hw_n = 1, sleep_exec = 0, irq_en = 1, end_zero = 0;
logic avs_read = 0, avs_write = 0, avs_waitrequest, xfer_start, xfer_done, cz;
logic [3:0] avs_address = '0;
logic [31:0] avs_writedata = '0, avs_readdata, q;
pdm_wake_type wake = '0;
pdm_power_type power;
pdm_state_type mode;
int n_fail = 0, checks = 0;
pdm_controller #(.SETTLE_CYC(4)) dut_u (.ref_clk, .reset_n, .chip_init_pin_n(init_n),
   .hw_powerdown_pin_n(hw_n), .sleep_exec, .wake, .module_irq_enable(irq_en), .xfer_done,
   .xfer_count_zero(cz), .power, .mode, .cpu_resume(), .irq_take(), .xfer_start, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest);
pdm_xfer_model xc_u (.ref_clk, .reset_n, .xfer_start, .end_at_zero(end_zero), .xfer_done,
   .xfer_count_zero(cz));
initial forever #5 ref_clk = ~ref_clk;
///////////////////////////////////////////////////////////////////////////
task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
   int n;
   @(posedge ref_clk);
   avs_address <= a;
   avs_write <= w;
   avs_read <= !w;
   avs_writedata <= d;
   n = 0;
   do
   begin
      @(posedge ref_clk);
      n++;
   end
   while (avs_waitrequest !== 1'b0 && n < 50);
   q = avs_readdata;
   if (avs_waitrequest !== 1'b0) n_fail++;
   avs_read <= 1'b0;
   avs_write <= 1'b0;
endtask
task sl;
   @(posedge ref_clk);
   sleep_exec <= 1'b1;
   @(posedge ref_clk);
   sleep_exec <= 1'b0;
endtask
// Bounded wait: pins pass a synchroniser first
task wm(input pdm_state_type m);
   for (int i = 0; i < 40 && mode !== m; i++) @(posedge ref_clk);
   `CHK("mode", m, mode)
endtask
task stay(input pdm_state_type m);
   repeat (8) @(posedge ref_clk);
   `CHK("mode", m, mode)
endtask
task final_report;
   if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
   else $display("MISMATCHES SEEN");
   $finish;
endtask
initial
begin
   repeat (5000) @(posedge ref_clk);
   n_fail++;
   final_report;
end
///////////////////////////////////////////////////////////////////////////
initial
begin
   repeat (2) @(posedge ref_clk);
   reset_n <= 1'b1;
   wm(PDM_ST_RUN);
   bus(0, 4'h0, 32'h0);
   `CHK("hw_powerdown_pin_n", 8'h7f, q[7:0])
   bus(1, 4'h4, 32'h1);
   bus(1, 4'h0, 32'h80);
   bus(0, 4'h0, 32'h0);
   `CHK("hw_powerdown_pin_n", 8'h7f, q[7:0])
   bus(1, 4'h4, 32'h30);
   bus(0, 4'hc, 32'h0);
   `CHK("unmapped", 32'h0, q)
   sl;
   wm(PDM_ST_SLEEP);
   `CHK("clk", 1'b1, power.clock_run)
   wake <= {1'b1, 3'h3, 2'b00};
   stay(PDM_ST_SLEEP);
   wake <= {1'b1, 3'h5, 2'b00};
   irq_en <= 1'b0;
   stay(PDM_ST_SLEEP);
   irq_en <= 1'b1;
   wm(PDM_ST_RUN);
   wake <= '0;
   for (int z = 0; z < 2; z++)
   begin
      end_zero <= z[0];
      sl;
      wm(PDM_ST_SLEEP);
      wake <= {1'b1, 3'h5, 2'b10};
      wm(PDM_ST_XFER);
      wake <= '0;
      wm(z ? PDM_ST_SLEEP : PDM_ST_RUN);
   end
   wake <= {1'b1, 3'h5, 2'b00};
   wm(PDM_ST_RUN);
   wake <= '0;
   bus(1, 4'h0, 32'h80);
   bus(0, 4'h0, 32'h0);
   `CHK("hw_powerdown_pin_n", 8'hff, q[7:0])
   sl;
   wm(PDM_ST_SW_HW_POWERDOWN_PIN_N);
   `CHK("clk", 1'b0, power.clock_run)
   wake <= {1'b1, 3'h7, 2'b00};
   stay(PDM_ST_SW_HW_POWERDOWN_PIN_N);
   wake <= 6'h01;
   wm(PDM_ST_NMI_WAKE);
   wake <= '0;
   wm(PDM_ST_RUN);
   bus(0, 4'h0, 32'h0);
   `CHK("hw_powerdown_pin_n", 8'h7f, q[7:0])
   sl;
   wm(PDM_ST_SLEEP);
   init_n <= 1'b0;
   wm(PDM_ST_RESET);
   init_n <= 1'b1;
   wm(PDM_ST_RUN);
   bus(1, 4'h0, 32'h80);
   sl;
   wm(PDM_ST_SW_HW_POWERDOWN_PIN_N);
   // Standby pin, init pin and NMI all at once
   hw_n <= 1'b0;
   init_n <= 1'b0;
   wake <= 6'h01;
   wm(PDM_ST_HW_HW_POWERDOWN_PIN_N);
   `CHK("hiz", 1'b1, power.ports_hiz)
   wake <= '0;
   hw_n <= 1'b1;
   stay(PDM_ST_RESET);
   init_n <= 1'b1;
   wm(PDM_ST_RUN);
   bus(0, 4'h0, 32'h0);
   `CHK("hw_powerdown_pin_n", 8'h7f, q[7:0])
   final_report;
end
endmodule
